/* File: hw/mpm_pkg.sv */
package mpm_pkg;

  // ****************************************************************
  // Register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
  localparam logic [7:0] ADDR_MON_SEL = 8'h10;
  localparam logic [7:0] ADDR_STATE = 8'h14;

  // Control register fields
  localparam int CTRL_MON_EN_BIT = 0;
  localparam int CTRL_INV_BIT = 1;
  localparam int CTRL_EQU_LSB = 4;
  localparam int EQU_W = 3;
  localparam logic [2:0] EQU_RESET = 3'h5;

  // Monitor select register: one byte per monitored word
  localparam int SEL_FIELD_W = 8;

  // State register fields
  localparam int STATE_CNT_LSB = 0;
  localparam int STATE_BUSY_BIT = 8;
  localparam int STATE_WIDX_LSB = 12;

  // Interrupt event bits
  localparam int N_EVT = 5;
  localparam int EVT_REAL = 0;
  localparam int EVT_REACT = 1;
  localparam int EVT_AUX1 = 2;
  localparam int EVT_AUX2 = 3;
  localparam int EVT_OVF = 4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ = 200_000_000;
  localparam int CLK_NS = 5;
  localparam int ENG_CYC_NS = 203;
  localparam int ENG_CYC = (ENG_CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int ENG_HALF = ENG_CYC / 2;
  localparam int MON_BITS = 35;
  localparam int MON_WORDS = 4;
  localparam longint SLOW_HZ = 32_768;
  localparam longint FRAME_SLOW_CYC = 13;
  localparam int FRAME_CYC_DEF = int'((FRAME_SLOW_CYC * CLK_HZ) / SLOW_HZ);
  localparam int SIGN_FIFO_BITS = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MS_IDLE, MS_ADDR, MS_WAIT, MS_LOAD, MS_SHIFT
  } mpm_mon_e;

  typedef struct packed {
    logic push;
    logic real_sign;
    logic react_sign;
  } mpm_sign_s;

  typedef struct packed {
    logic real_energy_pulse;
    logic reactive_energy_pulse;
    logic aux_first_pin;
    logic aux_second_pin;
  } mpm_pulse_s;

endpackage : mpm_pkg

/* File: hw/mpm_top.sv */
// Chosen here: the register offsets and the APB register port.
module mpm_top
  import mpm_pkg::*;
#(
  parameter int FRAME_CYC = FRAME_CYC_DEF,
  parameter int RAM_AW = 8,
  parameter int RAM_DW = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pass_start,
  input wire mpm_sign_s sign_in,
  input wire logic [1:0] aux_in,
  output logic [RAM_AW-1:0] ram_addr,
  input wire logic [RAM_DW-1:0] ram_rdata,
  output logic test_mux_output_pin,
  output logic test_output_clock,
  output mpm_pulse_s pulse_pins,
  output logic [EQU_W-1:0] meter_equation_select,
  output logic irq
);

  // ****************************************************************
  // Derived sizes
  // ****************************************************************
  // Two sign bits per entry, so the 8-bit store holds four entries
  localparam int FIFO_DEPTH = SIGN_FIFO_BITS / 2;
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int SUB_CYC = FRAME_CYC / FIFO_DEPTH;
  localparam int SUB_HALF = SUB_CYC / 2;
  localparam int SW = $clog2(SUB_CYC + 1);
  localparam int EW = $clog2(ENG_CYC + 1);
  localparam int BW = $clog2(MON_BITS + 1);

  typedef struct packed {
    logic mon_en;
    logic inv;
    logic [EQU_W-1:0] equ;
    logic [N_EVT-1:0] ist;
    logic [N_EVT-1:0] ien;
    logic [MON_WORDS-1:0][RAM_AW-1:0] sel;
    mpm_mon_e ms;
    logic [1:0] widx;
    logic [BW-1:0] bitc;
    logic [EW-1:0] ecnt;
    logic [RAM_DW-1:0] sh;
    logic tclk;
    logic tdo;
    logic [RAM_AW-1:0] raddr;
    logic [FIFO_DEPTH-1:0][1:0] fmem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [SW-1:0] scnt;
    logic wpl;
    logic vpl;
    logic [1:0] aux;
    mpm_pulse_s pins;
    logic [31:0] rdata;
  } mpm_state_s;

  mpm_state_s s_q;
  mpm_state_s s_d;

  function automatic logic [PW-1:0] mpm_inc(input logic [PW-1:0] p);
    mpm_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : mpm_inc

  // Logical level to pin level; the pin idles high unless inverted
  function automatic logic mpm_pin(input logic lvl, input logic inv);
    mpm_pin = inv ? lvl : ~lvl;
  endfunction : mpm_pin

  logic acc;
  logic setup;
  logic wr;
  logic mapped;
  logic pop;
  logic push;
  logic [N_EVT-1:0] evt;
  logic [N_EVT-1:0] clr;

  assign acc = psel & penable;
  assign setup = psel & ~penable;
  assign wr = acc & pwrite & ce;
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_IRQ_STAT) ||
                  (paddr == ADDR_IRQ_EN) || (paddr == ADDR_IRQ_CLR) ||
                  (paddr == ADDR_MON_SEL) || (paddr == ADDR_STATE);
  // Zero-wait slave; a frozen block holds the master off
  assign pready = ce;
  assign pslverr = acc & ~mapped;
  assign prdata = s_q.rdata;

  always_comb begin
    s_d = s_q;
    evt = '0;
    clr = '0;
    push = 1'b0;
    pop = 1'b0;

    // ****************************************************************
    // Register access
    // ****************************************************************
    if (wr) begin
      unique case (paddr)
        ADDR_CTRL: begin
          s_d.mon_en = pwdata[CTRL_MON_EN_BIT];
          s_d.inv = pwdata[CTRL_INV_BIT];
          s_d.equ = pwdata[CTRL_EQU_LSB +: EQU_W];
        end
        ADDR_IRQ_EN: s_d.ien = pwdata[N_EVT-1:0];
        ADDR_IRQ_CLR: clr = pwdata[N_EVT-1:0];
        ADDR_MON_SEL: begin
          for (int i = 0; i < MON_WORDS; i++) begin
            s_d.sel[i] = RAM_AW'(pwdata[i*SEL_FIELD_W +: SEL_FIELD_W]);
          end
        end
        default: ;
      endcase
    end
    if (setup) begin
      s_d.rdata = '0;
      unique case (paddr)
        ADDR_CTRL: begin
          s_d.rdata[CTRL_MON_EN_BIT] = s_q.mon_en;
          s_d.rdata[CTRL_INV_BIT] = s_q.inv;
          s_d.rdata[CTRL_EQU_LSB +: EQU_W] = s_q.equ;
        end
        ADDR_IRQ_STAT: s_d.rdata[N_EVT-1:0] = s_q.ist;
        ADDR_IRQ_EN: s_d.rdata[N_EVT-1:0] = s_q.ien;
        ADDR_MON_SEL: begin
          for (int i = 0; i < MON_WORDS; i++) begin
            s_d.rdata[i*SEL_FIELD_W +: SEL_FIELD_W] =
              SEL_FIELD_W'(s_q.sel[i]);
          end
        end
        ADDR_STATE: begin
          s_d.rdata[STATE_CNT_LSB +: CW] = s_q.cnt;
          s_d.rdata[STATE_BUSY_BIT] = (s_q.ms != MS_IDLE);
          s_d.rdata[STATE_WIDX_LSB +: 2] = s_q.widx;
        end
        default: ;
      endcase
    end

    // ****************************************************************
    // Word monitor
    // ****************************************************************
    unique case (s_q.ms)
      MS_IDLE: begin
        s_d.tdo = 1'b0;
        s_d.tclk = 1'b0;
        if (pass_start && s_q.mon_en) begin
          s_d.widx = '0;
          s_d.ms = MS_ADDR;
        end
      end
      MS_ADDR: begin
        s_d.raddr = s_q.sel[s_q.widx];
        s_d.ms = MS_WAIT;
      end
      // Synchronous RAM: data is valid one cycle after the address
      MS_WAIT: s_d.ms = MS_LOAD;
      MS_LOAD: begin
        s_d.sh = ram_rdata;
        s_d.tdo = 1'b1;
        s_d.tclk = 1'b1;
        s_d.bitc = '0;
        s_d.ecnt = '0;
        s_d.ms = MS_SHIFT;
      end
      MS_SHIFT: begin
        s_d.ecnt = s_q.ecnt + EW'(1);
        s_d.tclk = (s_d.ecnt < EW'(ENG_HALF));
        if (s_q.ecnt == EW'(ENG_CYC - 1)) begin
          s_d.ecnt = '0;
          s_d.tclk = 1'b1;
          if (s_q.bitc == BW'(MON_BITS - 1)) begin
            s_d.tdo = 1'b0;
            s_d.tclk = 1'b0;
            s_d.widx = s_q.widx + 2'(1);
            s_d.ms = (s_q.widx == 2'(MON_WORDS - 1)) ? MS_IDLE : MS_ADDR;
          end else begin
            s_d.bitc = s_q.bitc + BW'(1);
            // Data follows the flag MSB first; the tail bits are zero
            s_d.tdo = (s_q.bitc < BW'(RAM_DW)) ? s_q.sh[RAM_DW-1] : 1'b0;
            s_d.sh = {s_q.sh[RAM_DW-2:0], 1'b0};
          end
        end
      end
    endcase
    // Dropping the enable aborts the word in flight at once
    if (!s_q.mon_en) begin
      s_d.ms = MS_IDLE;
      s_d.tdo = 1'b0;
      s_d.tclk = 1'b0;
    end

    // ****************************************************************
    // Sign-bit FIFO and real/reactive pulses
    // ****************************************************************
    s_d.scnt = (s_q.scnt == SW'(SUB_CYC - 1)) ? '0 : s_q.scnt + SW'(1);
    if (s_q.scnt == '0 && s_q.cnt != '0) begin
      pop = 1'b1;
      s_d.wpl = s_q.fmem[s_q.rp][1];
      s_d.vpl = s_q.fmem[s_q.rp][0];
      s_d.rp = mpm_inc(s_q.rp);
    end else if (s_q.scnt == SW'(SUB_HALF)) begin
      s_d.wpl = 1'b0;
      s_d.vpl = 1'b0;
    end
    if (sign_in.push) begin
      if (s_q.cnt == CW'(FIFO_DEPTH) && !pop) begin
        // Full: the newest pair is dropped and flagged
        evt[EVT_OVF] = 1'b1;
      end else begin
        push = 1'b1;
        s_d.fmem[s_q.wp] = {sign_in.real_sign, sign_in.react_sign};
        s_d.wp = mpm_inc(s_q.wp);
      end
    end
    s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);

    // ****************************************************************
    // Aux pulses, pins and interrupts
    // ****************************************************************
    if (pass_start) begin
      s_d.aux = aux_in;
    end
    s_d.pins.real_energy_pulse = mpm_pin(s_d.wpl, s_d.inv);
    s_d.pins.reactive_energy_pulse = mpm_pin(s_d.vpl, s_d.inv);
    s_d.pins.aux_first_pin = mpm_pin(s_d.aux[0], s_d.inv);
    s_d.pins.aux_second_pin = mpm_pin(s_d.aux[1], s_d.inv);
    evt[EVT_REAL] = s_d.wpl & ~s_q.wpl;
    evt[EVT_REACT] = s_d.vpl & ~s_q.vpl;
    evt[EVT_AUX1] = s_d.aux[0] ^ s_q.aux[0];
    evt[EVT_AUX2] = s_d.aux[1] ^ s_q.aux[1];
    // An event in the clearing cycle survives the clear
    s_d.ist = (s_q.ist & ~clr) | evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.equ <= EQU_RESET;
      s_q.ms <= MS_IDLE;
      s_q.pins <= '1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign ram_addr = s_q.raddr;
  assign test_mux_output_pin = s_q.tdo;
  assign test_output_clock = s_q.tclk;
  assign pulse_pins = s_q.pins;
  assign meter_equation_select = s_q.equ;
  assign irq = |(s_q.ist & s_q.ien);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking mpm_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_mon_start_pass: assert property (
    (ce && s_q.mon_en && pass_start && s_q.ms == MS_IDLE)
      |=> s_q.ms == MS_ADDR)
    else $error("monitor did not start on pass");

  a_mon_off_quiet: assert property (
    (ce && !s_q.mon_en) |=> (s_q.ms == MS_IDLE && !s_q.tdo))
    else $error("monitor active while disabled");

  a_word_flag_bit: assert property (
    (ce && s_q.ms == MS_LOAD && s_q.mon_en) |=> (s_q.tdo && s_q.bitc == '0))
    else $error("monitor word lacks leading flag");

  a_bit_duration: assert property (
    (ce && s_q.ms == MS_SHIFT && s_q.ecnt != EW'(ENG_CYC - 1)
     && s_q.mon_en) |=> $stable(s_q.bitc))
    else $error("monitor bit shorter than engine cycle");

  a_pulse_polarity: assert property (
    (ce && s_q.inv == s_d.inv) |=>
      pulse_pins.real_energy_pulse == (s_q.inv ? s_q.wpl : ~s_q.wpl))
    else $error("pulse polarity wrong");

  a_aux_per_pass: assert property (
    (ce && !pass_start) |=> $stable(s_q.aux))
    else $error("aux pulse changed outside pass start");

  a_fifo_bound: assert property (
    s_q.cnt <= CW'(FIFO_DEPTH))
    else $error("sign fifo count out of range");

  a_drain_slot: assert property (
    (ce && s_q.scnt == '0 && s_q.cnt != '0) |=> s_q.rp == mpm_inc($past(s_q.rp)))
    else $error("sign fifo not drained in its slot");

  a_frame_slot: assert property (
    s_q.scnt < SW'(SUB_CYC))
    else $error("sub-interval counter overran frame slice");

  a_irq_level: assert property (
    (ce && |(evt & s_q.ien)) |=> irq)
    else $error("enabled event did not raise interrupt");

  a_set_over_clear: assert property (
    (ce && |evt) |=> ((s_q.ist & $past(evt)) == $past(evt)))
    else $error("status clear won over a new event");

  a_fifo_overflow: assert property (
    (ce && sign_in.push && s_q.cnt == CW'(FIFO_DEPTH) && !pop)
      |=> s_q.ist[EVT_OVF])
    else $error("sign fifo overflow not flagged");

  a_pulse_half_slot: assert property (
    (ce && s_q.scnt == SW'(SUB_HALF)) |=> (!s_q.wpl && !s_q.vpl))
    else $error("energy pulse outlived half a slot");

  a_aux_pin_level: assert property (
    ce |=> pulse_pins.aux_first_pin == (s_q.inv ? s_q.aux[0] : ~s_q.aux[0]))
    else $error("first aux pin does not show its level");

endmodule : mpm_top

/* File: test/mpm_ram_model.sv */
module mpm_ram_model
  import mpm_pkg::*;
(
  input wire logic pclk,
  input wire logic [7:0] ram_addr,
  output logic [31:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Content follows from the address so the bench can predict every word
  always @(posedge pclk) begin
    ram_rdata <= {ram_addr, ~ram_addr, ram_addr ^ 8'h5A, ram_addr + 8'h01};
  end
endmodule : mpm_ram_model

/* File: test/mpm_top_tb.sv */
module mpm_top_tb
  import mpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRAME = 64;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic pass_start = 0, pready, pslverr, mux_pin, tclk, irq, err;
  logic [7:0] paddr = '0, ram_addr;
  logic [31:0] pwdata = '0, prdata, ram_rdata, rd, wd, sel;
  logic [1:0] aux_in = '0, a;
  logic [2:0] equ;
  mpm_sign_s sign_in = '0;
  mpm_pulse_s pins;
  logic [31:0] exp_q[$];
  integer seed = 48529, bad_count = 0, tests_run = 0, cyc = 0;
  integer i, nr, nv, cr, cv, s;

  always #2.5 pclk = ~pclk;

  mpm_top #(.FRAME_CYC(FRAME)) DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pass_start(pass_start), .sign_in(sign_in), .aux_in(aux_in),
    .ram_addr(ram_addr), .ram_rdata(ram_rdata),
    .test_mux_output_pin(mux_pin), .test_output_clock(tclk),
    .pulse_pins(pins), .meter_equation_select(equ), .irq(irq)
  );
  mpm_ram_model RAM (.pclk(pclk), .ram_addr(ram_addr),
    .ram_rdata(ram_rdata));

  task end_of_test;
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Idle cycle after each transfer keeps psel from toggling in one step
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Ends once pready is high; only the bench timeout ends a wait on a stuck slave
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task pass;
    pass_start <= 1'b1;
    @(posedge pclk);
    pass_start <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pass

  task get_word;
    integer k;
    for (k = 0; k < 200 && mux_pin !== 1'b1; k++) @(posedge pclk);
    repeat (10) @(posedge pclk);
    chk(tclk, 1);
    for (k = 0; k < 34; k++) begin
      repeat (ENG_CYC) @(posedge pclk);
      if (k < 32) wd = {wd[30:0], mux_pin};
      else chk(mux_pin, 0);
    end
  endtask : get_word

  task count_pulses;
    integer k;
    logic [1:0] pv;
    cr = 0; cv = 0; pv = 2'b11;
    for (k = 0; k < 2 * FRAME; k++) begin
      @(posedge pclk);
      cr += pv[1] & ~pins.real_energy_pulse;
      cv += pv[0] & ~pins.reactive_energy_pulse;
      pv = {pins.real_energy_pulse, pins.reactive_energy_pulse};
    end
  endtask : count_pulses

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(pins, 4'hF);
    apb(1'b0, ADDR_CTRL, '0);
    chk(rd, 32'h50);
    for (i = 2; i < 6; i++) begin
      apb(1'b1, ADDR_CTRL, i << 4);
      chk(equ, i);
    end
    for (i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_CTRL, (i << 1) | 32'h50);
      a = $random(seed);
      aux_in <= a;
      pass();
      aux_in <= ~a;
      repeat (2) @(posedge pclk);
      chk(pins, {{2{~i[0]}}, ~{a[0], a[1]} ^ {2{i[0]}}});
    end
    apb(1'b1, ADDR_CTRL, 32'h50);
    apb(1'b1, ADDR_IRQ_CLR, 32'h1F);
    apb(1'b1, ADDR_IRQ_EN, 32'h4);
    pass();
    chk(irq, 1);
    apb(1'b0, ADDR_IRQ_STAT, '0);
    chk(rd[3:2], 2'b11);
    apb(1'b1, ADDR_IRQ_EN, 32'h0);
    chk(irq, 0);
    apb(1'b1, ADDR_IRQ_EN, 32'h4);
    apb(1'b1, ADDR_IRQ_CLR, 32'h1F);
    chk(irq, 0);
    apb(1'b0, ADDR_IRQ_CLR, '0);
    chk(rd, 0);
    nr = 0; nv = 0;
    for (i = 0; i < 3; i++) begin
      s = $random(seed);
      sign_in <= '{1'b1, s[0], s[1]};
      nr += s[0]; nv += s[1];
      @(posedge pclk);
      sign_in <= '0;
      @(posedge pclk);
    end
    count_pulses();
    chk(cr, nr);
    chk(cv, nv);
    apb(1'b0, ADDR_IRQ_STAT, '0);
    chk(rd[0], nr != 0);
    sign_in <= '{1'b1, 1'b1, 1'b1};
    repeat (6) @(posedge pclk);
    sign_in <= '0;
    apb(1'b0, ADDR_IRQ_STAT, '0);
    chk(rd[4], 1);
    sel = $random(seed);
    for (i = 0; i < 4; i++) begin
      a = 0;
      exp_q.push_back({sel[8*i+:8], ~sel[8*i+:8], sel[8*i+:8] ^ 8'h5A,
        sel[8*i+:8] + 8'h01});
    end
    apb(1'b1, ADDR_MON_SEL, sel);
    apb(1'b1, ADDR_CTRL, 32'h51);
    pass();
    for (i = 0; i < 4; i++) begin
      get_word();
      chk(wd, exp_q.pop_front());
    end
    // A pass after the last word has gone out starts another, which the disable then aborts
    repeat (40) @(posedge pclk);
    pass();
    repeat (60) @(posedge pclk);
    apb(1'b1, ADDR_CTRL, 32'h50);
    @(posedge pclk);
    chk(mux_pin, 0);
    apb(1'b0, ADDR_STATE, '0);
    chk(rd[8], 0);
    apb(1'b0, 8'hFC, '0);
    chk(err, 1);
    chk(rd, 0);
    end_of_test();
  end
endmodule : mpm_top_tb
